// ==== rtl/phy_led_strap_reset_control.sv ====
// Purpose: indicator drive, strap capture, config inputs, reset and power-down control
// Assumes: link status inputs come from logic on pclk; pins are asynchronous
// Notes: indicator and config pins pass two flip-flops before use
// What this block does
// - low-speed indicator on at 10 Mb/s
// - latch low-speed, activity, link straps bits 7-5
// - latch duplex and high-speed straps bits 4-3
// - activity indicator blinks 10 Hz on traffic
// - link indicator on, blinks with traffic
// - duplex indicator on in full duplex
// - duplex indicator blinks 20 Hz on collision in half duplex
// - high-speed indicator on at 100 Mb/s
// - autoneg uses both config inputs for advertisement
// - first config input sets coding bypass bit
// - second config input sets loopback bit
// - power-up reset lasts more than 1 ms
// - reset-done low until reset finished
// - power-down is pin OR control bit
// - power-down floats line and indicators, isolates MII
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/1ns
`include "phy_misc_consts.svh"
module phy_led_strap_reset_control
#(
    parameter int unsigned RESET_CYCLES = `CLK_PER_US * `RESET_MIN_TIME_US + 1,
    parameter int unsigned SLOW_HALF = `CLK_FREQ_HZ / (2 * `BLINK_ACT_HZ),
    parameter int unsigned FAST_HALF = `CLK_FREQ_HZ / (2 * `BLINK_COL_HZ)
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic reset_pin_n,
    output logic reset_done,
    input wire logic pwrdn_pin,
    input wire logic config_strap_a,
    input wire logic config_strap_b,
    input wire logic link_good,
    input wire logic speed_100,
    input wire logic activity,
    input wire logic full_duplex,
    input wire logic collision,
    input wire logic [`LED_COUNT-1:0] led_in,
    output logic [`LED_COUNT-1:0] led_out,
    output logic [`LED_COUNT-1:0] led_oe_n,
    output logic line_tx_oe_n,
    output logic mii_isolate,
    output logic power_down,
    output logic autoneg_enable,
    output logic coding_bypass,
    output logic loopback_enable,
    output logic [1:0] adv_select
);
    localparam int EXT_W = `LED_COUNT + 4;
    localparam int RCW = $clog2(RESET_CYCLES + 1);
    localparam logic [RCW-1:0] RST_LAST = RCW'(RESET_CYCLES - 1);

    // ======================================================================
    // input synchronisers
    logic [EXT_W-1:0] ext_raw;
    logic [EXT_W-1:0] ext_meta_reg;
    logic [EXT_W-1:0] ext_sync_reg;
    logic rst_pin_s;
    logic pwrdn_s;
    logic cfg_b_s;
    logic cfg_a_s;
    logic [`LED_COUNT-1:0] led_s;

    assign ext_raw = {reset_pin_n, pwrdn_pin, config_strap_b, config_strap_a, led_in};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ext_meta_reg <= '0;
            ext_sync_reg <= '0;
        end
        else
        begin
            ext_meta_reg <= ext_raw;
            ext_sync_reg <= ext_meta_reg;
        end
    end

    assign {rst_pin_s, pwrdn_s, cfg_b_s, cfg_a_s, led_s} = ext_sync_reg;

    // ======================================================================
    // reset sequencer
    phy_misc_pkg::rst_state_t state_reg;
    phy_misc_pkg::rst_state_t state_next;
    logic [RCW-1:0] rst_cnt_reg;
    logic done_reg;
    logic strap_take;

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            phy_misc_pkg::RST_HOLD:
                state_next = phy_misc_pkg::RST_COUNT;
            phy_misc_pkg::RST_COUNT:
                if (rst_cnt_reg == RST_LAST)
                    state_next = phy_misc_pkg::RST_DONE;
            phy_misc_pkg::RST_DONE:
                state_next = phy_misc_pkg::RST_DONE;
            default:
                state_next = phy_misc_pkg::RST_HOLD;
        endcase
        if (!rst_pin_s)
            state_next = phy_misc_pkg::RST_HOLD;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_reg <= phy_misc_pkg::RST_HOLD;
        else
            state_reg <= state_next;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rst_cnt_reg <= '0;
        else if (state_reg != phy_misc_pkg::RST_COUNT || !rst_pin_s)
            rst_cnt_reg <= '0;
        else if (rst_cnt_reg != RST_LAST)
            rst_cnt_reg <= rst_cnt_reg + 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            done_reg <= 1'b0;
        else
            done_reg <= (state_next == phy_misc_pkg::RST_DONE);
    end

    assign reset_done = done_reg;
    assign strap_take = (state_reg == phy_misc_pkg::RST_COUNT) && (state_next == phy_misc_pkg::RST_DONE);

    // ======================================================================
    // strap capture: indicators are floated during reset so pins show pulls
    logic [`LED_COUNT-1:0] strap_reg;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            strap_reg <= `STRAP_RESET;
        else if (strap_take)
            strap_reg <= led_s;
    end

    // ======================================================================
    // apb decode
    logic setup;
    logic access;
    logic addr_ok;
    logic wr_basic;
    logic wr_coding;

    assign setup = psel && !penable;
    assign access = psel && penable;
    assign addr_ok = (paddr == `OFS_BASIC_CTRL) || (paddr == `OFS_CODING_CTRL) ||
                     (paddr == `OFS_STRAP_STATUS) || (paddr == `OFS_ADVERTISE) ||
                     (paddr == `OFS_INDICATOR);
    assign pready = 1'b1;
    assign pslverr = access && (!addr_ok || (pwrite && !done_reg));
    assign wr_basic = access && pwrite && done_reg && (paddr == `OFS_BASIC_CTRL);
    assign wr_coding = access && pwrite && done_reg && (paddr == `OFS_CODING_CTRL);

    // ======================================================================
    // control registers except adv_reg, returned to reset values until reset is done
    logic autoneg_reg;
    logic loopback_reg;
    logic pd_bit_reg;
    logic bypass_reg;
    logic [1:0] adv_reg;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            autoneg_reg <= `AUTONEG_RESET;
            pd_bit_reg <= `POWER_DOWN_RESET;
        end
        else if (!done_reg)
        begin
            autoneg_reg <= `AUTONEG_RESET;
            pd_bit_reg <= `POWER_DOWN_RESET;
        end
        else if (wr_basic)
        begin
            autoneg_reg <= pwdata[`BIT_AUTONEG];
            pd_bit_reg <= pwdata[`BIT_POWER_DOWN];
        end
    end

    // config inputs override software while autoneg is off
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            loopback_reg <= `LOOPBACK_RESET;
        else if (!autoneg_reg)
            loopback_reg <= cfg_b_s;
        else if (!done_reg)
            loopback_reg <= `LOOPBACK_RESET;
        else if (wr_basic)
            loopback_reg <= pwdata[`BIT_LOOPBACK];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            bypass_reg <= `BYPASS_RESET;
        else if (!autoneg_reg)
            bypass_reg <= cfg_a_s;
        else if (!done_reg)
            bypass_reg <= `BYPASS_RESET;
        else if (wr_coding)
            bypass_reg <= pwdata[`BIT_BYPASS];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            adv_reg <= `ADVERTISE_RESET;
        else if (autoneg_reg)
            adv_reg <= {cfg_b_s, cfg_a_s};
    end

    assign autoneg_enable = autoneg_reg;
    assign loopback_enable = loopback_reg;
    assign coding_bypass = bypass_reg;
    assign adv_select = adv_reg;

    // ======================================================================
    // power-down
    logic pd_reg;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pd_reg <= 1'b0;
        else
            pd_reg <= pwrdn_s || pd_bit_reg;
    end

    assign power_down = pd_reg;
    assign line_tx_oe_n = pd_reg;
    assign mii_isolate = pd_reg;
    assign led_oe_n = {`LED_COUNT{pd_reg || !done_reg}};

    // ======================================================================
    // indicators
    blink_if bl ();
    logic [`LED_COUNT-1:0] led_reg;

    assign bl.run = done_reg;

    blink_divider #(
        .SLOW_HALF(SLOW_HALF),
        .FAST_HALF(FAST_HALF)
    ) u_blink (
        .pclk(pclk),
        .presetn(presetn),
        .bl(bl.gen)
    );

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            led_reg <= '0;
        else
        begin
            led_reg[`LED_SPEED10] <= link_good && !speed_100;
            led_reg[`LED_SPEED100] <= link_good && speed_100;
            led_reg[`LED_ACTIVITY] <= activity && bl.phase[0];
            led_reg[`LED_LINK] <= link_good && (!activity || bl.phase[0]);
            led_reg[`LED_DUPCOL] <= full_duplex || (collision && bl.phase[1]);
        end
    end

    assign led_out = led_reg;

    // ======================================================================
    // register read data, loaded in the setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= '0;
        else if (setup)
        begin
            prdata <= '0;
            unique case (paddr)
                `OFS_BASIC_CTRL:
                begin
                    prdata[`BIT_LOOPBACK] <= loopback_reg;
                    prdata[`BIT_AUTONEG] <= autoneg_reg;
                    prdata[`BIT_POWER_DOWN] <= pd_bit_reg;
                end
                `OFS_CODING_CTRL:
                    prdata[`BIT_BYPASS] <= bypass_reg;
                `OFS_STRAP_STATUS:
                    prdata[`STRAP_MSB:`STRAP_LSB] <= strap_reg;
                `OFS_ADVERTISE:
                    prdata[1:0] <= adv_reg;
                `OFS_INDICATOR:
                    prdata[`LED_COUNT:0] <= {pd_reg, led_reg};
                default:
                    prdata <= '0;
            endcase
        end
    end

    // ======================================================================
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_speed10;
        (link_good && !speed_100) |=> led_out[`LED_SPEED10];
    endproperty
    a_speed10: assert property (p_speed10) else $error("low-speed indicator off at 10 Mb/s");

    property p_strap_hi;
        $rose(done_reg) |-> strap_reg[4:2] == $past(led_s[4:2]);
    endproperty
    a_strap_hi: assert property (p_strap_hi) else $error("straps 7-5 not captured");

    property p_strap_lo;
        $rose(done_reg) |-> strap_reg[1:0] == $past(led_s[1:0]);
    endproperty
    a_strap_lo: assert property (p_strap_lo) else $error("straps 4-3 not captured");

    property p_activity;
        activity |=> led_out[`LED_ACTIVITY] == $past(bl.phase[0]);
    endproperty
    a_activity: assert property (p_activity) else $error("activity indicator not blinking");

    property p_link;
        (link_good && !activity) |=> led_out[`LED_LINK];
    endproperty
    a_link: assert property (p_link) else $error("link indicator off with good link");

    property p_fdx;
        full_duplex |=> led_out[`LED_DUPCOL];
    endproperty
    a_fdx: assert property (p_fdx) else $error("duplex indicator off in full duplex");

    property p_col;
        (!full_duplex && collision) |=> led_out[`LED_DUPCOL] == $past(bl.phase[1]);
    endproperty
    a_col: assert property (p_col) else $error("collision blink wrong");

    property p_speed100;
        (link_good && speed_100) |=> led_out[`LED_SPEED100] && !led_out[`LED_SPEED10];
    endproperty
    a_speed100: assert property (p_speed100) else $error("high-speed indicator wrong");

    property p_adv;
        autoneg_reg |=> adv_select == {$past(cfg_b_s), $past(cfg_a_s)};
    endproperty
    a_adv: assert property (p_adv) else $error("advertisement not following config inputs");

    property p_bypass;
        !autoneg_reg |=> coding_bypass == $past(cfg_a_s);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass bit not following input");

    property p_loop;
        !autoneg_reg |=> loopback_enable == $past(cfg_b_s);
    endproperty
    a_loop: assert property (p_loop) else $error("loopback bit not following input");

    property p_rst_len;
        $rose(done_reg) |-> $past(rst_cnt_reg) == RST_LAST;
    endproperty
    a_rst_len: assert property (p_rst_len) else $error("reset finished early");

    property p_done_low;
        !rst_pin_s |=> !reset_done ##1 !reset_done;
    endproperty
    a_done_low: assert property (p_done_low) else $error("reset-done high during reset");

    property p_pd;
        (pwrdn_s || pd_bit_reg) |=> power_down;
    endproperty
    a_pd: assert property (p_pd) else $error("power-down not entered");

    property p_float;
        power_down |-> (&led_oe_n) && line_tx_oe_n && mii_isolate;
    endproperty
    a_float: assert property (p_float) else $error("outputs driven in power-down");

    c_done: cover property ($rose(done_reg));
    c_pd: cover property ($rose(power_down));
    c_col: cover property (!full_duplex && collision && bl.phase[1]);
    c_act: cover property (activity && led_out[`LED_ACTIVITY]);

endmodule : phy_led_strap_reset_control

// ==== rtl/phy_misc_consts.svh ====
// Purpose: named constants for the indicator, strap and reset control block
// Assumes: 32-bit apb data, 12-bit byte address
// Notes: timing counts are derived from these figures inside the modules
`ifndef PHY_MISC_CONSTS_SVH
`define PHY_MISC_CONSTS_SVH

// ==========================================================================
// clock and timing
`define CLK_FREQ_HZ 250000000
`define CLK_PER_US 250
`define RESET_MIN_TIME_US 1000
`define BLINK_ACT_HZ 10
`define BLINK_COL_HZ 20

// ==========================================================================
// register byte offsets
`define OFS_BASIC_CTRL 12'h000
`define OFS_CODING_CTRL 12'h004
`define OFS_STRAP_STATUS 12'h008
`define OFS_ADVERTISE 12'h00c
`define OFS_INDICATOR 12'h010

// ==========================================================================
// field positions
`define BIT_LOOPBACK 14
`define BIT_AUTONEG 12
`define BIT_POWER_DOWN 11
`define BIT_BYPASS 1
`define STRAP_LSB 3
`define STRAP_MSB 7

// indicator pin indices; strap bit = index + STRAP_LSB
`define LED_SPEED10 4
`define LED_ACTIVITY 3
`define LED_LINK 2
`define LED_DUPCOL 1
`define LED_SPEED100 0
`define LED_COUNT 5

// ==========================================================================
// reset values
`define AUTONEG_RESET 1'h1
`define LOOPBACK_RESET 1'h0
`define POWER_DOWN_RESET 1'h0
`define BYPASS_RESET 1'h0
`define STRAP_RESET 5'h00
`define ADVERTISE_RESET 2'h0

`endif

// ==== rtl/phy_misc_pkg.sv ====
// Purpose: shared types for the indicator, strap and reset control block
// Assumes: constants live in phy_misc_consts.svh
// Notes: none
package phy_misc_pkg;

    // ======================================================================
    // internal reset sequencer
    typedef enum logic [1:0]
    {
        RST_HOLD = 2'b00,
        RST_COUNT = 2'b01,
        RST_DONE = 2'b10
    } rst_state_t;

endpackage : phy_misc_pkg

// ==== rtl/blink_if.sv ====
// Purpose: carries the blink run request and the two blink phases
// Assumes: single clock domain
// Notes: phase[0] is the slow blink, phase[1] the fast blink
`timescale 1ns/1ns
interface blink_if;
    logic run;
    logic [1:0] phase;

    modport gen
    (
        input run,
        output phase
    );

    modport user
    (
        output run,
        input phase
    );
endinterface : blink_if

// ==== rtl/blink_divider.sv ====
// Purpose: divides the clock down to the two indicator blink rates
// Assumes: run is low while the device is in reset
// Notes: each phase toggles once per half period
`timescale 1ns/1ns
`include "phy_misc_consts.svh"
module blink_divider
#(
    parameter int unsigned SLOW_HALF = `CLK_FREQ_HZ / (2 * `BLINK_ACT_HZ),
    parameter int unsigned FAST_HALF = `CLK_FREQ_HZ / (2 * `BLINK_COL_HZ)
)
(
    input wire logic pclk,
    input wire logic presetn,
    blink_if.gen bl
);
    localparam int CW = $clog2(SLOW_HALF + 1);

    logic [CW-1:0] cnt_reg [2];
    logic [1:0] phase_reg;

    // ======================================================================
    // one counter and phase per blink rate
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_rate
            localparam int unsigned HALF = (g == 0) ? SLOW_HALF : FAST_HALF;
            localparam logic [CW-1:0] LAST = CW'(HALF - 1);
            logic wrap;
            assign wrap = (cnt_reg[g] == LAST);

            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    cnt_reg[g] <= '0;
                else if (!bl.run || wrap)
                    cnt_reg[g] <= '0;
                else
                    cnt_reg[g] <= cnt_reg[g] + 1'b1;
            end

            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    phase_reg[g] <= 1'b0;
                else if (!bl.run)
                    phase_reg[g] <= 1'b0;
                else if (wrap)
                    phase_reg[g] <= ~phase_reg[g];
            end

            property p_phase_wrap;
                @(posedge pclk) disable iff (!presetn)
                (bl.run && wrap) |=> (bl.run == 1'b0 || phase_reg[g] != $past(phase_reg[g]));
            endproperty
            a_phase_wrap: assert property (p_phase_wrap) else $error("blink phase missed its wrap");
        end
    endgenerate

    assign bl.phase = phase_reg;

endmodule : blink_divider

// ==== tb/board_model.sv ====
// Purpose: board side of the block: strap resistors on the indicator pins and system reset
// Assumes: one clock; pulse asks for one reset of RST_LOW cycles
// Notes: a released indicator pin shows its resistor level
`timescale 1ns/1ns
module board_model
#(
    parameter logic [4:0] STRAPS = 5'h16,
    parameter int RST_LOW = 30
)
(
    input wire logic pclk,
    input wire logic pulse,
    input wire logic [4:0] led_out,
    input wire logic [4:0] led_oe_n,
    output logic reset_pin_n,
    output logic [4:0] led_in
);
    int cnt = 0;
    // ======================================================================
    // pins
    always_comb
        for (int i = 0; i < 5; i++)
            led_in[i] = led_oe_n[i] ? STRAPS[i] : led_out[i];
    // ======================================================================
    // system reset, held low for the whole minimum time
    always @(posedge pclk)
        cnt <= pulse ? RST_LOW : (cnt > 0 ? cnt - 1 : 0);
    assign reset_pin_n = (cnt == 0);
endmodule : board_model

// ==== tb/tb_top.sv ====
// Purpose: self-checking bench for the indicator, strap and reset block
// Assumes: reset and blink counts scaled down by parameters
// Notes: blink checks count lit cycles over two slow periods
`timescale 1ns/1ns
`include "phy_misc_consts.svh"
module tb_top;
    localparam int RC = 20;
    localparam int SH = 8;
    localparam int FH = 4;
    localparam int RL = 30;
    localparam logic [4:0] STRAPS = 5'h16;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic [11:0] paddr = 12'h0;
    logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pwrdn_pin = 1'h0, pulse = 1'h0;
    logic strap_a = 1'h0, strap_b = 1'h0, link_good = 1'h0, speed_100 = 1'h0;
    logic activity = 1'h0, full_duplex = 1'h0, collision = 1'h0;
    logic [31:0] pwdata = 32'h0, prdata, q, rnd = 32'h7ade;
    logic pready, pslverr, e, reset_pin_n, reset_done, line_tx_oe_n, mii_isolate, power_down;
    logic autoneg_enable, coding_bypass, loopback_enable;
    logic [1:0] adv_select;
    logic [4:0] led_in, led_out, led_oe_n, s;
    int err_total = 0, checks_done = 0, n;
    int h[5];
    always #2 pclk = ~pclk;

    phy_led_strap_reset_control #(.RESET_CYCLES(RC), .SLOW_HALF(SH), .FAST_HALF(FH))
    phy_led_strap_reset_control_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .reset_pin_n(reset_pin_n), .reset_done(reset_done), .pwrdn_pin(pwrdn_pin),
        .config_strap_a(strap_a), .config_strap_b(strap_b), .link_good(link_good),
        .speed_100(speed_100), .activity(activity), .full_duplex(full_duplex),
        .collision(collision), .led_in(led_in), .led_out(led_out), .led_oe_n(led_oe_n),
        .line_tx_oe_n(line_tx_oe_n), .mii_isolate(mii_isolate), .power_down(power_down),
        .autoneg_enable(autoneg_enable), .coding_bypass(coding_bypass),
        .loopback_enable(loopback_enable), .adv_select(adv_select));
    board_model #(.STRAPS(STRAPS), .RST_LOW(RL)) board_model_inst (.pclk(pclk), .pulse(pulse),
        .led_out(led_out), .led_oe_n(led_oe_n), .reset_pin_n(reset_pin_n), .led_in(led_in));

    // ======================================================================
    // model: lit cycles per 32-cycle window, -1 where unspecified
    function automatic int exp_high(input int k, input logic [4:0] v);
        // v = {link_good, speed_100, activity, full_duplex, collision}
        case (k)
            4: return v[4] ? (v[3] ? 0 : 32) : -1;
            3: return v[2] ? 16 : 0;
            2: return v[4] ? (v[2] ? 16 : 32) : 0;
            1: return v[1] ? 32 : (v[0] ? 16 : 0);
            default: return v[4] ? (v[3] ? 32 : 0) : -1;
        endcase
    endfunction : exp_high

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : report_and_stop

    task automatic chk_pin(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_pin

    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'h1;
        penable <= 1'h0;
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'h1 && n < 50);
        if (n >= 50)
        begin
            err_total++;
            report_and_stop();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    task automatic chk_rd(input logic [11:0] a, input logic [31:0] exp, input logic xe);
        apb(a, 1'h0, 32'h0);
        chk_pin(q, exp);
        chk_pin(e, xe);
    endtask : chk_rd

    task automatic wait_done(input logic v, input int lim);
        n = 0;
        while (reset_done !== v && n < lim)
        begin
            @(posedge pclk);
            #1 n++;
        end
        if (reset_done !== v)
        begin
            err_total++;
            report_and_stop();
        end
    endtask : wait_done

    task automatic chk_pd(input logic [7:0] exp);
        repeat (6) @(posedge pclk);
        #1 chk_pin({power_down, line_tx_oe_n, mii_isolate, led_oe_n}, exp);
        @(posedge pclk);
    endtask : chk_pd

    initial
    begin
        repeat (100000) @(posedge pclk);
        err_total++;
        report_and_stop();
    end

    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'h1;
        wait_done(1'h1, RC + 40);
        chk_pin(n >= RC, 1'h1);
        chk_rd(`OFS_STRAP_STATUS, {24'h0, STRAPS, 3'h0}, 1'h0);
        chk_rd(`OFS_BASIC_CTRL, 32'h1000, 1'h0);
        chk_rd(12'h020, 32'h0, 1'h1);
        chk_pin(led_oe_n, 5'h00);
        // every status combination, blink counted over whole periods
        for (int i = 0; i < 32; i++)
        begin
            s = 5'(i);
            @(posedge pclk);
            {link_good, speed_100, activity, full_duplex, collision} <= s;
            repeat (4) @(posedge pclk);
            h = '{default: 0};
            repeat (32)
            begin
                @(posedge pclk);
                #1;
                for (int k = 0; k < 5; k++)
                    if (led_out[k] === 1'h1)
                        h[k]++;
            end
            for (int k = 0; k < 5; k++)
                if (exp_high(k, s) >= 0)
                    chk_pin(h[k], exp_high(k, s));
        end
        // config inputs, autoneg off then on
        for (int m = 0; m < 2; m++)
        begin
            apb(`OFS_BASIC_CTRL, 1'h1, m ? 32'h1000 : 32'h0);
            for (int i = 0; i < 6; i++)
            begin
                rnd = lfsr(rnd);
                {strap_b, strap_a} <= rnd[1:0];
                repeat (6) @(posedge pclk);
                if (m == 0)
                begin
                    chk_pin({autoneg_enable, loopback_enable, coding_bypass}, {1'h0, rnd[1:0]});
                    chk_rd(`OFS_CODING_CTRL, {30'h0, rnd[0], 1'h0}, 1'h0);
                    chk_rd(`OFS_BASIC_CTRL, {17'h0, rnd[1], 14'h0}, 1'h0);
                end
                else
                begin
                    chk_pin({autoneg_enable, adv_select}, {1'h1, rnd[1:0]});
                    chk_rd(`OFS_ADVERTISE, {30'h0, rnd[1:0]}, 1'h0);
                end
            end
        end
        // power-down from the pin and from the control bit
        pwrdn_pin <= 1'h1;
        chk_pd(8'hff);
        pwrdn_pin <= 1'h0;
        chk_pd(8'h00);
        apb(`OFS_BASIC_CTRL, 1'h1, 32'h1800);
        chk_pd(8'hff);
        apb(`OFS_BASIC_CTRL, 1'h1, 32'h1000);
        chk_pd(8'h00);
        // external reset through the pin
        pulse <= 1'h1;
        @(posedge pclk);
        pulse <= 1'h0;
        wait_done(1'h0, 20);
        apb(`OFS_BASIC_CTRL, 1'h1, 32'h4000);
        chk_pin(e, 1'h1);
        chk_pin(led_oe_n, 5'h1f);
        wait_done(1'h1, RL + RC + 40);
        chk_rd(`OFS_BASIC_CTRL, 32'h1000, 1'h0);
        report_and_stop();
    end
endmodule : tb_top
